// >>> rtl/mcip_pkg.sv
/*
  Package for the memory controller init and power-status block.
  Assumes a single clk_sys domain and an Avalon-MM register slave.
*/
package mcip_pkg;

  // Register word offsets (byte addresses)
  localparam logic [3:0] CFGA_OFS  = 4'h0;
  localparam logic [3:0] CTRL_OFS  = 4'h4;
  localparam logic [3:0] STAT_OFS  = 4'h8;

  // Configuration register A fields
  localparam int PWR_UP_BIT        = 22;
  localparam int PWR_DWN_BIT       = 23;
  localparam int FAULT_LSB         = 0;
  localparam int FAULT_W           = 8;

  // Control register fields
  localparam int CTRL_INHIBIT_ROM_DECODE_BIT = 0;
  localparam int CTRL_FAILEN_BIT   = 1;
  localparam int CTRL_ROM_BIT      = 2;
  localparam int CTRL_CAP_LSB      = 4;
  localparam int CTRL_CAP_W        = 3;

  // Reset and unmapped-read values
  localparam logic [31:0] CTRL_RST = 32'h0000_0014;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  // Starting address encoding, units of 4 MB on bits 21:18
  localparam logic [3:0] START_0MB  = 4'h0;
  localparam logic [3:0] START_4MB  = 4'h1;
  localparam logic [3:0] START_8MB  = 4'h2;
  localparam logic [3:0] START_12MB = 4'h3;

  // Backplane time states
  typedef enum logic [1:0] {
    TS_T0,
    TS_T1,
    TS_T2,
    TS_T3
  } mcip_tstate_t;

  // Avalon-MM request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } mcip_avreq_t;

  // Bus lines sampled from the backplane (active high here)
  typedef struct packed {
    logic clear_request;
    logic dead;
    logic ac_low;
    logic dc_low;
  } mcip_busin_t;

endpackage : mcip_pkg

// >>> rtl/mcip_init_power.sv
/*
  Init and power-status logic: init lines, battery backup, power-up/down
  flags, FAIL/ALERT drive, starting-address encode and address match.
  Assumes bus inputs synchronous to clk_sys and a TS_DIV-cycle-per-state
  time-state sequencer T0..T3 free-running on clk_sys enable pulses.
*/
`timescale 1ns/1ps
module mcip_init_power #(
  parameter int TS_DIV = 4
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // Avalon-MM slave
  input  wire mcip_pkg::mcip_avreq_t av_req,
  output logic [31:0]               av_readdata,
  output logic                      av_waitrequest,
  // Backplane lines, active high after pin inversion
  input  wire mcip_pkg::mcip_busin_t bus_in,
  // Jumpers, active low (grounded = 0)
  input  wire logic                 start_jumper_low_n,
  input  wire logic                 start_jumper_high_n,
  // Fault flag set events from the array logic
  input  wire logic [7:0]           fault_set,
  // Memory address for decode
  input  wire logic [21:18]         mem_addr_hi,
  output logic                      addr_match,
  // Init and power outputs
  output logic [2:0]                system_init_lines_n,
  output logic                      clear_request_received,
  output logic                      power_not_good,
  output logic                      dc_low_or_dead,
  output logic                      battery_backup_mode,
  output logic                      battery_backup_mode_n,
  output logic [3:0]                start_address_bits,
  // Bus FAIL / ALERT, open drain: o is zero, oe high while pulling
  output logic                      bus_fail_line_o,
  output logic                      bus_fail_line_oe,
  output logic                      bus_alert_o,
  output logic                      bus_alert_oe
);

  mcip_pkg::mcip_tstate_t ts_r;
  logic [7:0]  div_r;
  logic        ts_en;
  logic [31:0] ctrl_r;
  logic [7:0]  fault_r;
  logic [7:0]  fault_clr;
  logic        stage1_r;
  logic        stage2_r;
  logic        pwr_up_r;
  logic        pwr_dwn_r;
  logic        clr_seen_r;
  logic        clear_power_up_pulse;
  logic        clear_power_down_pulse;
  logic        wr_cfga;
  logic        wr_ctrl;
  logic        acc_r;
  logic        flags_on;
  logic [3:0]  start_nxt;
  logic [3:0]  cap;
  logic [4:0]  top;

  // Time-state enable divider
  assign ts_en = (div_r == 8'(TS_DIV - 1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_r <= 8'h00;
    end else if (ts_en) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ts_r <= mcip_pkg::TS_T0;
    end else if (ts_en) begin
      case (ts_r)
        mcip_pkg::TS_T0: ts_r <= mcip_pkg::TS_T1;
        mcip_pkg::TS_T1: ts_r <= mcip_pkg::TS_T2;
        mcip_pkg::TS_T2: ts_r <= mcip_pkg::TS_T3;
        mcip_pkg::TS_T3: ts_r <= mcip_pkg::TS_T0;
        default:         ts_r <= mcip_pkg::TS_T0;
      endcase
    end
  end

  // latch at T2, assert at next T0
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clr_seen_r <= 1'b0;
    end else if (ts_en && ts_r == mcip_pkg::TS_T1) begin
      // external CPU is the only source
      clr_seen_r <= bus_in.clear_request;
    end
  end

  // received clear follows the latch at T0
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clear_request_received <= 1'b0;
    end else if (ts_en && ts_r == mcip_pkg::TS_T3) begin
      clear_request_received <= clr_seen_r;
    end
  end

  // power not good taken at T3
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      power_not_good <= 1'b1;
    end else if (ts_en && ts_r == mcip_pkg::TS_T2) begin
      power_not_good <= bus_in.dead | bus_in.dc_low;
    end
  end

  // coincident with power not good, same sample
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dc_low_or_dead <= 1'b1;
    end else if (ts_en && ts_r == mcip_pkg::TS_T2) begin
      dc_low_or_dead <= bus_in.dead | bus_in.dc_low;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      battery_backup_mode   <= 1'b1;
      battery_backup_mode_n <= 1'b0;
    end else begin
      battery_backup_mode   <= dc_low_or_dead;
      battery_backup_mode_n <= ~dc_low_or_dead;
    end
  end

  for (genvar gi = 0; gi < 3; gi++) begin : g_init
    // One flop per line, so each load group has its own driver
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        system_init_lines_n[gi] <= 1'b0;
      end else begin
        system_init_lines_n[gi] <= ~(clear_request_received | power_not_good);
      end
    end
  end

  // sensing stages, cleared while no low present; first preset by AC low alone or DC low alone, second by DC low alone
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else if (ts_en && ts_r == mcip_pkg::TS_T3) begin
      // AC low presets first stage only
      stage1_r <= (bus_in.ac_low & ~bus_in.dc_low) | (bus_in.dc_low & ~bus_in.ac_low);
      stage2_r <= bus_in.dc_low & ~bus_in.ac_low;
    end
  end

  // Register writes and clear pulses
  // Writes land on the edge that sees waitrequest low, never earlier
  assign wr_cfga = av_req.write && acc_r && av_req.address == mcip_pkg::CFGA_OFS;
  assign wr_ctrl = av_req.write && acc_r && av_req.address == mcip_pkg::CTRL_OFS;
  // write one makes the clear pulse
  assign clear_power_up_pulse   = wr_cfga && av_req.byteenable[2]
                                  && av_req.writedata[mcip_pkg::PWR_UP_BIT];
  assign clear_power_down_pulse = wr_cfga && av_req.byteenable[2]
                                  && av_req.writedata[mcip_pkg::PWR_DWN_BIT];
  assign flags_on = ctrl_r[mcip_pkg::CTRL_INHIBIT_ROM_DECODE_BIT];

  // order classifies; flags set at T3 after the J setup at T0
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_dwn_r <= 1'b0;
    end else if (!flags_on) begin
      pwr_dwn_r <= 1'b0;
    end else if (ts_en && ts_r == mcip_pkg::TS_T2 && stage1_r && !stage2_r) begin
      // Set beats clear in the same cycle
      pwr_dwn_r <= 1'b1;
    end else if (clear_power_down_pulse) begin
      pwr_dwn_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_up_r <= 1'b0;
    end else if (!flags_on) begin
      pwr_up_r <= 1'b0;
    end else if (ts_en && ts_r == mcip_pkg::TS_T2 && stage1_r && stage2_r) begin
      pwr_up_r <= 1'b1;
    end else if (clear_power_up_pulse) begin
      pwr_up_r <= 1'b0;
    end
  end

  // fault flags cleared by power not good; write one clears
  assign fault_clr = (wr_cfga && av_req.byteenable[0])
                     ? av_req.writedata[mcip_pkg::FAULT_LSB +: mcip_pkg::FAULT_W] : 8'h00;

  for (genvar fi = 0; fi < mcip_pkg::FAULT_W; fi++) begin : g_fault
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        fault_r[fi] <= 1'b0;
      end else if (power_not_good) begin
        fault_r[fi] <= 1'b0;
      end else if (fault_set[fi]) begin
        // Set beats a write-one clear in the same cycle
        fault_r[fi] <= 1'b1;
      end else if (fault_clr[fi]) begin
        fault_r[fi] <= 1'b0;
      end
    end
  end

  // Control register, software-set jumper and option bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= mcip_pkg::CTRL_RST;
    end else if (wr_ctrl && av_req.byteenable[0]) begin
      ctrl_r <= {24'h000000, 1'b0, av_req.writedata[6:4], 1'b0, av_req.writedata[2:0]};
    end
  end

  // FAIL with ROM and fail enable on AC low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_fail_line_oe <= 1'b0;
    end else begin
      // no ROM means FAIL never driven
      bus_fail_line_oe <= ctrl_r[mcip_pkg::CTRL_ROM_BIT]
                          && ctrl_r[mcip_pkg::CTRL_FAILEN_BIT] && bus_in.ac_low;
    end
  end

  // ALERT without ROM on AC or DC low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_alert_oe <= 1'b0;
    end else begin
      bus_alert_oe <= !ctrl_r[mcip_pkg::CTRL_ROM_BIT]
                      && (bus_in.ac_low || bus_in.dc_low);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_fail_line_o <= 1'b0;
      bus_alert_o     <= 1'b0;
    end else begin
      bus_fail_line_o <= 1'b0;
      bus_alert_o     <= 1'b0;
    end
  end

  always_comb begin
    case ({~start_jumper_high_n, ~start_jumper_low_n})
      2'b00:   start_nxt = mcip_pkg::START_0MB;
      2'b01:   start_nxt = mcip_pkg::START_4MB;
      2'b10:   start_nxt = mcip_pkg::START_8MB;
      2'b11:   start_nxt = mcip_pkg::START_12MB;
      default: start_nxt = mcip_pkg::START_0MB;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_address_bits <= 4'h0;
    end else begin
      start_address_bits <= start_nxt;
    end
  end

  // match within capacity, in 4 MB units
  assign cap = {1'b0, ctrl_r[mcip_pkg::CTRL_CAP_LSB +: mcip_pkg::CTRL_CAP_W]};
  assign top = {1'b0, start_address_bits} + {1'b0, cap};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_match <= 1'b0;
    end else begin
      addr_match <= (mem_addr_hi >= start_address_bits)
                    && ({1'b0, mem_addr_hi} < top);
    end
  end

  // Avalon slave: one wait cycle, answer on the second cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_r <= 1'b0;
    end else begin
      acc_r <= (av_req.read || av_req.write) && !acc_r;
    end
  end

  // Registered so the port leaves a flop; idles high between requests
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      av_waitrequest <= 1'b1;
    end else begin
      av_waitrequest <= !((av_req.read || av_req.write) && !acc_r);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      av_readdata <= 32'h0000_0000;
    end else if (av_req.read && !acc_r) begin
      case (av_req.address)
        mcip_pkg::CFGA_OFS: av_readdata <= {8'h00, pwr_dwn_r, pwr_up_r, 14'h0000, fault_r};
        mcip_pkg::CTRL_OFS: av_readdata <= ctrl_r;
        mcip_pkg::STAT_OFS: av_readdata <= {24'h000000, start_address_bits,
                                            battery_backup_mode, power_not_good,
                                            clear_request_received, dc_low_or_dead};
        default:            av_readdata <= mcip_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

endmodule : mcip_init_power

// >>> tb/mcip_checker.sv
/* Port checker for the init and power block.
   Assumes binding to mcip_init_power, one clk_sys domain. */
`timescale 1ns/1ps
module mcip_checker #(
  parameter int TS_DIV = 4
) (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  // Register bus
  input wire mcip_pkg::mcip_avreq_t av_req,
  input wire logic                  av_waitrequest,
  // Backplane and jumpers
  input wire mcip_pkg::mcip_busin_t bus_in,
  input wire logic                  start_jumper_low_n,
  input wire logic                  start_jumper_high_n,
  // Outputs watched
  input wire logic [2:0]            system_init_lines_n,
  input wire logic                  clear_request_received,
  input wire logic                  power_not_good,
  input wire logic                  dc_low_or_dead,
  input wire logic                  battery_backup_mode,
  input wire logic                  battery_backup_mode_n,
  input wire logic [3:0]            start_address_bits,
  input wire logic                  bus_fail_line_o,
  input wire logic                  bus_fail_line_oe,
  input wire logic                  bus_alert_o
);
  // Slack of two time-state frames plus pipeline
  localparam int LAT = 8 * TS_DIV + 4;
  logic [1:0] jmp_r;
  logic [4:0] stab_r;
  logic       rom_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      jmp_r  <= 2'h0;
      stab_r <= 5'h00;
    end else begin
      jmp_r  <= {start_jumper_high_n, start_jumper_low_n};
      stab_r <= (jmp_r != {start_jumper_high_n, start_jumper_low_n}) ? 5'h00 :
                (stab_r == 5'h18) ? stab_r : stab_r + 5'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      rom_r <= mcip_pkg::CTRL_RST[mcip_pkg::CTRL_ROM_BIT];
    else if (av_req.write && !av_waitrequest && av_req.byteenable[0] &&
             av_req.address == mcip_pkg::CTRL_OFS)
      rom_r <= av_req.writedata[mcip_pkg::CTRL_ROM_BIT];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_req_new;
    (av_req.read || av_req.write) && !$past(av_req.read || av_req.write);
  endsequence
  sequence s_wait_go;
    av_waitrequest ##1 !av_waitrequest;
  endsequence
  AST_WAIT: assert property (s_req_new |-> s_wait_go)
    else $error("bus answer not in second cycle");
  AST_INIT: assert property (
    power_not_good && $past(power_not_good) |-> system_init_lines_n == 3'h0)
    else $error("init lines idle while power not good");
  AST_CLR: assert property (
    $rose(bus_in.clear_request) |-> ##[1:LAT] clear_request_received)
    else $error("clear request not received");
  AST_PNG: assert property (
    $rose(bus_in.dead) |-> ##[1:LAT] power_not_good)
    else $error("power not good missing after dead");
  AST_DLOD: assert property (dc_low_or_dead == power_not_good)
    else $error("dc low or dead differs from power not good");
  AST_BKUP: assert property (battery_backup_mode_n == !battery_backup_mode)
    else $error("backup outputs not complementary");
  AST_START: assert property (
    stab_r == 5'h18 |-> start_address_bits == {2'h0, ~jmp_r})
    else $error("start address encode wrong");
  AST_NOFAIL: assert property (
    !rom_r && !$past(rom_r) && !$past(rom_r, 2) |-> !bus_fail_line_oe)
    else $error("fail driven without boot rom");
  AST_OD: assert property (!bus_fail_line_o && !bus_alert_o)
    else $error("open drain output not low");
endmodule : mcip_checker
bind mcip_init_power mcip_checker #(.TS_DIV(TS_DIV)) i_chk (
  .clk_sys(clk_sys), .nrst(nrst), .av_req(av_req), .av_waitrequest(av_waitrequest),
  .bus_in(bus_in), .start_jumper_low_n(start_jumper_low_n),
  .start_jumper_high_n(start_jumper_high_n), .system_init_lines_n(system_init_lines_n),
  .clear_request_received(clear_request_received), .power_not_good(power_not_good),
  .dc_low_or_dead(dc_low_or_dead), .battery_backup_mode(battery_backup_mode),
  .battery_backup_mode_n(battery_backup_mode_n), .start_address_bits(start_address_bits),
  .bus_fail_line_o(bus_fail_line_o), .bus_fail_line_oe(bus_fail_line_oe),
  .bus_alert_o(bus_alert_o));

// >>> tb/mcip_backplane_model.sv
/* Backplane model: supply monitor, bus watchdog and CPU clear.
   Assumes the bench picks a step code; lines follow on clk_sys. */
`timescale 1ns/1ps
module mcip_backplane_model (
  // Clock
  input wire logic             clk_sys,
  // Step code from the bench
  input wire logic [2:0]       step,
  // Lines toward the controller
  output mcip_pkg::mcip_busin_t bus_in
);
  always @(posedge clk_sys) begin
    bus_in.clear_request <= (step == 3'h4);
    bus_in.dead          <= (step == 3'h3);
    bus_in.ac_low        <= (step == 3'h1) || (step == 3'h5);
    bus_in.dc_low        <= (step == 3'h2) || (step == 3'h5);
  end
endmodule : mcip_backplane_model

// >>> tb/tb_top.sv
/* Self-checking bench for the init and power block.
   Assumes the backplane model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed { logic [1:0] jmp; logic [3:0] st; } mcip_row_t;
  logic clk_sys = 1'b0, nrst = 1'b0, jl_n = 1'b1, jh_n = 1'b1, am, pg, dl, bm, bmn, cr;
  logic fo, foe, ao, aoe, wq;
  logic [2:0] step = 3'h0, il_n;
  logic [3:0] ma = 4'h0, sab;
  logic [7:0] fs = 8'h00;
  logic [31:0] rd, q;
  int mismatches = 0, tests_run = 0, cycles = 0;
  mcip_pkg::mcip_avreq_t av_req = '0;
  mcip_pkg::mcip_busin_t bus_in;
  mcip_row_t rows [4] = '{'{2'b11, mcip_pkg::START_0MB}, '{2'b10, mcip_pkg::START_4MB},
                          '{2'b01, mcip_pkg::START_8MB}, '{2'b00, mcip_pkg::START_12MB}};
  mcip_backplane_model i_bp (.clk_sys(clk_sys), .step(step), .bus_in(bus_in));
  mcip_init_power #(.TS_DIV(2)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .av_req(av_req), .av_readdata(rd),
    .av_waitrequest(wq), .bus_in(bus_in), .start_jumper_low_n(jl_n),
    .start_jumper_high_n(jh_n), .fault_set(fs), .mem_addr_hi(ma), .addr_match(am),
    .system_init_lines_n(il_n), .clear_request_received(cr), .power_not_good(pg),
    .dc_low_or_dead(dl), .battery_backup_mode(bm), .battery_backup_mode_n(bmn),
    .start_address_bits(sab), .bus_fail_line_o(fo), .bus_fail_line_oe(foe),
    .bus_alert_o(ao), .bus_alert_oe(aoe));
  always #2 clk_sys = ~clk_sys;
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    av_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    do @(posedge clk_sys); while (wq !== 1'b0);
    q = rd;
    av_req <= '0;
  endtask : bus
  task automatic go(input logic [2:0] s, input int n);
    @(posedge clk_sys);
    step <= s;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : go
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  initial begin
    repeat (4) @(posedge clk_sys);
    chk({29'h0, il_n}, 32'h0);
    nrst <= 1'b1;
    bus(1'b0, mcip_pkg::CTRL_OFS, 32'h0);
    chk(q, mcip_pkg::CTRL_RST);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, mcip_pkg::RDATA_UNMAPPED);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      {jh_n, jl_n} <= rows[i].jmp;
      go(3'h0, 30);
      chk({28'h0, sab}, {28'h0, rows[i].st});
    end
    @(posedge clk_sys);
    {jh_n, jl_n} <= 2'b11;
    go(3'h0, 30);
    chk({31'h0, am}, 32'h1);
    @(posedge clk_sys);
    ma <= 4'h5;
    go(3'h0, 4);
    chk({31'h0, am}, 32'h0);
    done("reset and jumpers");
    bus(1'b1, mcip_pkg::CTRL_OFS, 32'h17);
    go(3'h1, 40);
    chk({31'h0, foe}, 32'h1);
    bus(1'b0, mcip_pkg::CFGA_OFS, 32'h0);
    chk({31'h0, q[mcip_pkg::PWR_DWN_BIT]}, 32'h1);
    go(3'h5, 20);
    go(3'h0, 60);
    bus(1'b1, mcip_pkg::CFGA_OFS, 32'h00C0_0000);
    bus(1'b0, mcip_pkg::CFGA_OFS, 32'h0);
    chk({30'h0, q[23:22]}, 32'h0);
    done("power down with rom");
    bus(1'b1, mcip_pkg::CTRL_OFS, 32'h11);
    go(3'h1, 40);
    chk({30'h0, aoe, foe}, 32'h2);
    go(3'h0, 60);
    bus(1'b1, mcip_pkg::CTRL_OFS, 32'h10);
    bus(1'b1, mcip_pkg::CFGA_OFS, 32'h00C0_0000);
    go(3'h2, 40);
    bus(1'b0, mcip_pkg::CFGA_OFS, 32'h0);
    chk({30'h0, q[23:22]}, 32'h0);
    go(3'h0, 60);
    bus(1'b1, mcip_pkg::CTRL_OFS, 32'h11);
    bus(1'b1, mcip_pkg::CFGA_OFS, 32'h00C0_0000);
    go(3'h2, 40);
    bus(1'b0, mcip_pkg::CFGA_OFS, 32'h0);
    chk({31'h0, q[mcip_pkg::PWR_UP_BIT]}, 32'h1);
    chk({27'h0, aoe, pg, dl, bm, bmn}, 32'h1E);
    bus(1'b0, mcip_pkg::STAT_OFS, 32'h0);
    chk(q, 32'h0000_000D);
    go(3'h0, 60);
    done("power up");
    @(posedge clk_sys);
    fs <= 8'h01;
    @(posedge clk_sys);
    fs <= 8'h00;
    bus(1'b0, mcip_pkg::CFGA_OFS, 32'h0);
    chk({24'h0, q[7:0]}, 32'h1);
    go(3'h3, 40);
    chk({29'h0, il_n}, 32'h0);
    bus(1'b0, mcip_pkg::CFGA_OFS, 32'h0);
    chk({24'h0, q[7:0]}, 32'h0);
    go(3'h0, 60);
    go(3'h4, 40);
    chk({28'h0, cr, il_n}, 32'h8);
    go(3'h0, 60);
    done("faults and clear");
    @(posedge clk_sys);
    nrst <= 1'b0;
    go(3'h0, 2);
    chk({31'h0, pg}, 32'h1);
    @(posedge clk_sys);
    nrst <= 1'b1;
    go(3'h0, 20);
    chk({28'h0, pg, il_n}, 32'h7);
    done("second reset");
    tally_and_finish();
  end
endmodule : tb_top
